/* File: cvt_pkg.sv */
package cvt_pkg;

  // Register addresses; each 16-bit word is written at its low-byte address.
  localparam logic [7:0] CVT_CC_LOW_ADDR = 8'h02;
  localparam logic [7:0] CVT_CC_HIGH_ADDR = 8'h03;
  localparam logic [7:0] CVT_CV_LOW_ADDR = 8'h04;
  localparam logic [7:0] CVT_CV_HIGH_ADDR = 8'h05;

  // Charge voltage word layout: bit 15 reserved (invalid write), bits 14:3 code, bits 2:0 ignored.
  localparam int CVT_CV_WIDTH = 12;
  localparam int CVT_CV_LSB = 3;
  localparam int CVT_CV_MSB = 14;
  localparam int CVT_CV_RSVD_BIT = 15;
  localparam int CVT_CV_STEP_MV = 8;

  // Charge current word layout: bits 15:13 reserved (invalid write), bits 12:6 code, bits 5:0 ignored.
  localparam int CVT_CC_WIDTH = 7;
  localparam int CVT_CC_LSB = 6;
  localparam int CVT_CC_MSB = 12;
  localparam int CVT_CC_RSVD_LSB = 13;
  localparam int CVT_CC_STEP_MA = 64;

  // Accepted voltage range, 1024 mV to 19200 mV, as codes of 8 mV.
  localparam logic [11:0] CVT_CV_MIN_CODE = 12'h080;
  localparam logic [11:0] CVT_CV_MAX_CODE = 12'h960;

  // Power-on defaults for one to four cells: 4200, 8400, 12600 and 16800 mV.
  localparam logic [11:0] CVT_CV_DEF_1S = 12'h20D;
  localparam logic [11:0] CVT_CV_DEF_2S = 12'h41A;
  localparam logic [11:0] CVT_CV_DEF_3S = 12'h627;
  localparam logic [11:0] CVT_CV_DEF_4S = 12'h834;

  // Cell-count pin encodings.
  localparam logic [1:0] CVT_CELLS_1 = 2'h0;
  localparam logic [1:0] CVT_CELLS_2 = 2'h1;
  localparam logic [1:0] CVT_CELLS_3 = 2'h2;

  // Current clamps as 64 mA codes: 384 mA pre-charge, 2 A rounded down for one-cell early fast charge.
  localparam logic [6:0] CVT_PRE_CLAMP_CODE = 7'h06;
  localparam logic [6:0] CVT_FAST_CLAMP_CODE = 7'h1F;

  // One-cell battery thresholds in mV: 3000 mV leaves pre-charge, 3600 mV leaves linear mode.
  localparam logic [15:0] CVT_ONE_CELL_FAST_MV = 16'h0BB8;
  localparam logic [15:0] CVT_ONE_CELL_LINEAR_MV = 16'h0E10;

  localparam logic [15:0] CVT_ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    CVT_IDLE = 2'b00,
    CVT_PRECHARGE = 2'b01,
    CVT_FAST = 2'b10
  } cvt_phase_type;

  // One 16-bit register command from the serial front end.
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [15:0] data;
  } cvt_wr_type;

endpackage : cvt_pkg

/* File: cvt_charge_voltage_regs.sv */
`timescale 1ns/1ps

module cvt_charge_voltage_regs
  import cvt_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] cell_count_pin,
  input wire logic input_good_flag,
  input wire logic linear_pass_enable,
  input wire logic [15:0] battery_sense_mv,
  input wire logic [15:0] min_system_voltage_mv,
  input wire cvt_wr_type reg_wr,
  input wire logic [7:0] reg_rd_addr,
  output logic [15:0] reg_rd_data_reg,
  output logic [11:0] charge_voltage_target_reg,
  output logic [6:0] charge_current_target_reg,
  output logic [6:0] charge_current_limit_reg,
  output logic charge_enable_reg,
  output cvt_phase_type charge_phase_reg,
  output logic linear_pass_on_reg,
  output logic sys_at_min_reg
);

  // Default voltage code for the strapped cell count.
  function automatic logic [11:0] cv_default(input logic [1:0] cells);
    logic [11:0] code;
    code = CVT_CV_DEF_4S;
    if (cells == CVT_CELLS_1) begin
      code = CVT_CV_DEF_1S;
    end else if (cells == CVT_CELLS_2) begin
      code = CVT_CV_DEF_2S;
    end else if (cells == CVT_CELLS_3) begin
      code = CVT_CV_DEF_3S;
    end
    return code;
  endfunction : cv_default

  // Smaller of a requested current code and a clamp code.
  function automatic logic [6:0] clamp_code(input logic [6:0] req, input logic [6:0] lim);
    return (req > lim) ? lim : req;
  endfunction : clamp_code

  logic [11:0] cv_next;
  logic [6:0] cc_next;
  logic [6:0] limit_next;
  logic charge_en_next;
  cvt_phase_type phase_next;
  logic linear_next;
  logic sys_min_next;
  logic [15:0] rd_next;

  // Write decode works on the whole assembled word, never on a single byte.
  wire cv_wr = reg_wr.valid && (reg_wr.addr == CVT_CV_LOW_ADDR);
  wire cc_wr = reg_wr.valid && (reg_wr.addr == CVT_CC_LOW_ADDR);
  wire [11:0] cv_wr_code = reg_wr.data[CVT_CV_MSB:CVT_CV_LSB];
  wire cv_wr_zero = (reg_wr.data == CVT_ZERO_WORD);
  wire cv_wr_rsvd = reg_wr.data[CVT_CV_RSVD_BIT];
  wire cv_wr_in_range = (cv_wr_code >= CVT_CV_MIN_CODE) && (cv_wr_code <= CVT_CV_MAX_CODE);
  wire cv_accept = cv_wr && !cv_wr_zero && !cv_wr_rsvd && cv_wr_in_range;
  wire cv_force_cc_zero = cv_wr && cv_wr_zero;
  wire cc_wr_rsvd = |reg_wr.data[15:CVT_CC_RSVD_LSB];
  wire [6:0] cc_wr_code = reg_wr.data[CVT_CC_MSB:CVT_CC_LSB];
  wire cc_accept = cc_wr && !cc_wr_rsvd;
  wire one_cell = (cell_count_pin == CVT_CELLS_1);

  // Stored targets; a zero voltage write wins over a current write in the same cycle.
  assign cv_next = cv_accept ? cv_wr_code : charge_voltage_target_reg;
  assign cc_next = cv_force_cc_zero ? 7'h00 : (cc_accept ? cc_wr_code : charge_current_target_reg);

  // Charging needs good input power and a nonzero current; the voltage is whatever is stored, default included.
  assign charge_en_next = input_good_flag && (charge_current_target_reg != 7'h00);

  // Pre-charge ends at 3 V for one cell and at the minimum system voltage for larger packs.
  wire below_fast = one_cell ? (battery_sense_mv < CVT_ONE_CELL_FAST_MV)
                             : (battery_sense_mv < min_system_voltage_mv);
  wire below_linear_exit = battery_sense_mv < CVT_ONE_CELL_LINEAR_MV;
  assign phase_next = !charge_en_next ? CVT_IDLE : (below_fast ? CVT_PRECHARGE : CVT_FAST);

  // Current clamp and switch mode per phase; illegal phase codes cannot arise here.
  always_comb begin
    limit_next = 7'h00;
    linear_next = 1'b0;
    sys_min_next = 1'b0;
    unique case (phase_next)
      CVT_IDLE: begin
        limit_next = 7'h00;
      end
      CVT_PRECHARGE: begin
        limit_next = clamp_code(charge_current_target_reg, CVT_PRE_CLAMP_CODE);
        linear_next = linear_pass_enable;
        sys_min_next = !one_cell;
      end
      CVT_FAST: begin
        if (one_cell && below_linear_exit) begin
          limit_next = clamp_code(charge_current_target_reg, CVT_FAST_CLAMP_CODE);
          linear_next = linear_pass_enable;
        end else begin
          limit_next = charge_current_target_reg;
        end
      end
    endcase
  end

  // Read path: reserved bits always read back as zero.
  assign rd_next = (reg_rd_addr == CVT_CV_LOW_ADDR) ? {1'b0, charge_voltage_target_reg, 3'b000}
                 : (reg_rd_addr == CVT_CC_LOW_ADDR) ? {3'b000, charge_current_target_reg, 6'h00}
                 : CVT_ZERO_WORD;

  // Targets; reset loads the cell-count default and clears the current.
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_voltage_target_reg <= cv_default(cell_count_pin);
      charge_current_target_reg <= 7'h00;
    end else begin
      charge_voltage_target_reg <= cv_next;
      charge_current_target_reg <= cc_next;
    end
  end

  // Regulation controls derived from the stored targets and battery state.
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_enable_reg <= 1'b0;
      charge_phase_reg <= CVT_IDLE;
      charge_current_limit_reg <= 7'h00;
      linear_pass_on_reg <= 1'b0;
      sys_at_min_reg <= 1'b0;
      reg_rd_data_reg <= CVT_ZERO_WORD;
    end else begin
      charge_enable_reg <= charge_en_next;
      charge_phase_reg <= phase_next;
      charge_current_limit_reg <= limit_next;
      linear_pass_on_reg <= linear_next;
      sys_at_min_reg <= sys_min_next;
      reg_rd_data_reg <= rd_next;
    end
  end

  // Checks on the stored targets and regulation controls.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_reset_default: assert property (
    $past(srst) |-> charge_voltage_target_reg == cv_default($past(cell_count_pin)))
    else $error("Voltage target after reset does not match the cell-count default.");

  chk_range_accept: assert property (
    cv_accept |=> charge_voltage_target_reg == $past(cv_wr_code))
    else $error("Accepted voltage write was not stored.");

  chk_range_reject: assert property (
    (cv_wr && !cv_wr_in_range && !(cc_wr)) |=> $stable(charge_voltage_target_reg))
    else $error("Out-of-range voltage write changed the target.");

  chk_zero_write: assert property (
    cv_force_cc_zero |=> (charge_current_target_reg == 7'h00) && $stable(charge_voltage_target_reg) ##1
      !charge_enable_reg)
    else $error("Zero voltage write did not stop charge while keeping the target.");

  chk_reserved_top: assert property (
    (cv_wr && cv_wr_rsvd) |=> $stable(charge_voltage_target_reg))
    else $error("Voltage write with reserved top bit was not rejected.");

  chk_reserved_low: assert property (
    (reg_rd_addr == CVT_CV_LOW_ADDR) |=> (reg_rd_data_reg[2:0] == 3'b000) && !reg_rd_data_reg[15])
    else $error("Reserved voltage bits read back nonzero.");

  chk_charge_start: assert property (
    (input_good_flag && cc_accept && cc_wr_code != 7'h00 && !cv_wr) ##1 input_good_flag |=> charge_enable_reg)
    else $error("Charge did not start after a current write with good input.");

  chk_pre_clamp: assert property (
    (charge_phase_reg == CVT_PRECHARGE) |-> (charge_current_limit_reg <= CVT_PRE_CLAMP_CODE)
      && (sys_at_min_reg == (cell_count_pin != CVT_CELLS_1)))
    else $error("Pre-charge current or system rail control is wrong.");

  chk_one_cell_fast: assert property (
    ($past(one_cell) && !$past(below_fast) && $past(below_linear_exit)
      && charge_phase_reg == CVT_FAST) |-> charge_current_limit_reg <= CVT_FAST_CLAMP_CODE)
    else $error("One-cell fast charge below 3.6 V exceeded 2 A.");

  chk_linear_pass: assert property (
    (charge_phase_reg == CVT_PRECHARGE) |-> linear_pass_on_reg == $past(linear_pass_enable))
    else $error("Linear pass mode does not follow its enable during pre-charge.");

  // The stored target never leaves the accepted window, defaults included.
  chk_target_window: assert property (
    (charge_voltage_target_reg >= CVT_CV_MIN_CODE)
      && (charge_voltage_target_reg <= CVT_CV_MAX_CODE))
    else $error("Stored voltage target is outside the accepted range.");

  // Any refused voltage word, for whatever reason, leaves the target untouched.
  chk_refused_hold: assert property (
    (cv_wr && !cv_accept)
      |=> $stable(charge_voltage_target_reg))
    else $error("Refused voltage word changed the stored target.");

  // An accepted current word lands in one step unless a zero voltage write overrides it.
  chk_current_store: assert property (
    (cc_accept && !cv_force_cc_zero)
      |=> charge_current_target_reg == $past(cc_wr_code))
    else $error("Accepted current word was not stored.");

  // A current word with a reserved top bit set is dropped whole.
  chk_current_refused: assert property (
    (cc_wr && cc_wr_rsvd && !cv_force_cc_zero)
      |=> $stable(charge_current_target_reg))
    else $error("Current word with reserved bits changed the target.");

  // Without good input power the charger must stay off one cycle later.
  chk_enable_needs_input: assert property (
    !$past(input_good_flag)
      |-> !charge_enable_reg)
    else $error("Charge enabled without good input power.");

  // The enable and the phase come from the same next-state term, so they must agree.
  chk_enable_phase: assert property (
    charge_enable_reg
      == (charge_phase_reg != CVT_IDLE))
    else $error("Charge enable and phase disagree.");

  // In idle nothing drives current, the linear pass or the system rail hold.
  chk_idle_outputs: assert property (
    (charge_phase_reg == CVT_IDLE)
      |-> (charge_current_limit_reg == 7'h00) && !linear_pass_on_reg && !sys_at_min_reg)
    else $error("Idle phase left a regulation control active.");

  // Fast charge releases the system rail from its minimum hold.
  chk_fast_rail_free: assert property (
    (charge_phase_reg == CVT_FAST)
      |-> !sys_at_min_reg)
    else $error("System rail held at minimum during fast charge.");

  // A one-cell pack only sits in pre-charge while it is below the fast threshold.
  chk_one_cell_pre: assert property (
    (charge_phase_reg == CVT_PRECHARGE && $past(one_cell))
      |-> $past(below_fast))
    else $error("One-cell pack in pre-charge above the fast threshold.");

  // Larger packs never keep the switch linear once fast charge begins.
  chk_multi_linear_off: assert property (
    (charge_phase_reg == CVT_FAST && !$past(one_cell))
      |-> !linear_pass_on_reg)
    else $error("Multi-cell fast charge left the switch in linear mode.");

  // A zero voltage write wins over a current write in the same cycle.
  chk_zero_beats_current: assert property (
    (cv_force_cc_zero && cc_wr)
      |=> charge_current_target_reg == 7'h00)
    else $error("Current write overrode a zero voltage write.");

  // Reset clears the current target, so charging never resumes by itself.
  chk_reset_current: assert property (
    $past(srst)
      |-> (charge_current_target_reg == 7'h00) && !charge_enable_reg)
    else $error("Current target or enable not cleared by reset.");

  // Current reads show the code with its reserved bits as zero.
  chk_read_current: assert property (
    (reg_rd_addr == CVT_CC_LOW_ADDR)
      |=> (reg_rd_data_reg[5:0] == 6'h00) && (reg_rd_data_reg[15:13] == 3'b000))
    else $error("Reserved current bits read back nonzero.");

  // Voltage reads place the stored code at bits 14 to 3.
  chk_read_voltage: assert property (
    (reg_rd_addr == CVT_CV_LOW_ADDR)
      |=> reg_rd_data_reg[CVT_CV_MSB:CVT_CV_LSB] == $past(charge_voltage_target_reg))
    else $error("Voltage read does not show the stored code.");

  // Main scenarios worth seeing at least once.
  cov_refused_write: cover property (cv_wr && cv_wr_rsvd);
  cov_voltage_set: cover property (cv_accept ##1 cc_accept ##2 charge_enable_reg);
  cov_zero_stop: cover property (charge_enable_reg ##1 cv_force_cc_zero ##2 !charge_enable_reg);
  cov_pre_to_fast: cover property (charge_phase_reg == CVT_PRECHARGE ##1 charge_phase_reg == CVT_FAST);
  cov_one_cell_clamp: cover property (one_cell && charge_phase_reg == CVT_FAST && linear_pass_on_reg);

endmodule : cvt_charge_voltage_regs

/* File: cvt_host_model.sv */
`timescale 1ns/1ps

// Host on the register port; it sends one whole 16-bit word per command.
module cvt_host_model
  import cvt_pkg::*;
(
  input wire logic clk,
  output cvt_wr_type reg_wr
);
  initial reg_wr = '0;

  // One command per call, spaced by an idle cycle so valid is never set twice in one step.
  // A scenario may pass a word with the reserved top bit set on purpose to see it refused.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk);
    reg_wr.valid <= 1'b0;
  endtask : wr
endmodule : cvt_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import cvt_pkg::*;
  logic clk;
  logic srst;
  logic [1:0] cell_count_pin;
  logic input_good_flag;
  logic linear_pass_enable;
  logic [15:0] battery_sense_mv;
  logic [15:0] min_system_voltage_mv;
  logic [7:0] reg_rd_addr;
  cvt_wr_type reg_wr;
  logic [15:0] rd;
  logic [11:0] cv;
  logic [6:0] cc;
  logic [6:0] lim;
  logic en;
  cvt_phase_type phase;
  logic lin;
  logic sysmin;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [11:0] defs [4] = '{CVT_CV_DEF_1S, CVT_CV_DEF_2S, CVT_CV_DEF_3S, CVT_CV_DEF_4S};
  logic [15:0] words [7] = '{16'h0400, 16'h03f8, 16'h4b00, 16'h4b08, 16'h8400, 16'h7ff8, 16'h2007};

  cvt_host_model cvt_host_model_i (.clk(clk), .reg_wr(reg_wr));

  cvt_charge_voltage_regs cvt_charge_voltage_regs_i (.clk(clk), .srst(srst), .cell_count_pin(cell_count_pin),
    .input_good_flag(input_good_flag), .linear_pass_enable(linear_pass_enable), .battery_sense_mv(battery_sense_mv),
    .min_system_voltage_mv(min_system_voltage_mv), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data_reg(rd), .charge_voltage_target_reg(cv), .charge_current_target_reg(cc),
    .charge_current_limit_reg(lim), .charge_enable_reg(en), .charge_phase_reg(phase),
    .linear_pass_on_reg(lin), .sys_at_min_reg(sysmin));

  // Free-running clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A hang ends the run as a mismatch; the tests need well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Reset is held ten cycles while the strap is steady, so the default is sampled cleanly.
  task automatic rst(input logic [1:0] c);
    @(posedge clk);
    cell_count_pin <= c;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
  endtask : rst

  // Regulation outputs lag an input change or a stored write by up to two edges.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd_addr <= a;
    @(posedge clk);
    #1;
    chk("read data", e, rd);
  endtask : rdchk

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rst(i[1:0]);
      chk("cv default", 16'(defs[i]), 16'(cv));
      chk("cc reset", 16'h0000, 16'(cc));
      rdchk(CVT_CV_LOW_ADDR, {1'b0, defs[i], 3'b000});
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_range();
    logic [11:0] e;
    rst(2'h0);
    e = CVT_CV_DEF_1S;
    foreach (words[i]) begin
      if (!words[i][15] && words[i][14:3] >= CVT_CV_MIN_CODE && words[i][14:3] <= CVT_CV_MAX_CODE) e = words[i][14:3];
      cvt_host_model_i.wr(CVT_CV_LOW_ADDR, words[i]);
      #1;
      chk("cv write", 16'(e), 16'(cv));
    end
    rdchk(CVT_CV_LOW_ADDR, 16'h2000);
    $display("t_range done");
  endtask : t_range

  task automatic t_one_cell();
    rst(2'h0);
    input_good_flag <= 1'b1;
    battery_sense_mv <= 16'h07d0;
    cvt_host_model_i.wr(CVT_CV_LOW_ADDR, 16'h2000);
    cvt_host_model_i.wr(CVT_CC_LOW_ADDR, 16'h1000);
    settle();
    chk("enable", 16'h0001, 16'(en));
    chk("phase", 16'(CVT_PRECHARGE), 16'(phase));
    chk("limit", 16'h0006, 16'(lim));
    chk("linear", 16'h0001, 16'(lin));
    linear_pass_enable <= 1'b0;
    settle();
    chk("linear off", 16'h0000, 16'(lin));
    linear_pass_enable <= 1'b1;
    settle();
    battery_sense_mv <= 16'h0ce4;
    settle();
    chk("phase", 16'(CVT_FAST), 16'(phase));
    chk("limit", 16'h001f, 16'(lim));
    chk("linear", 16'h0001, 16'(lin));
    battery_sense_mv <= 16'h0e10;
    settle();
    chk("limit", 16'h0040, 16'(lim));
    chk("linear", 16'h0000, 16'(lin));
    cvt_host_model_i.wr(CVT_CV_LOW_ADDR, 16'h0000);
    settle();
    chk("cv kept", 16'h0400, 16'(cv));
    chk("cc zero", 16'h0000, 16'(cc));
    chk("enable", 16'h0000, 16'(en));
    $display("t_one_cell done");
  endtask : t_one_cell

  task automatic t_multi_cell();
    rst(2'h1);
    battery_sense_mv <= 16'h1388;
    min_system_voltage_mv <= 16'h1770;
    cvt_host_model_i.wr(CVT_CC_LOW_ADDR, 16'h0200);
    cvt_host_model_i.wr(CVT_CC_LOW_ADDR, 16'h2040);
    settle();
    chk("cc", 16'h0008, 16'(cc));
    chk("cv default used", 16'(CVT_CV_DEF_2S), 16'(cv));
    chk("sys at min", 16'h0001, 16'(sysmin));
    chk("limit", 16'h0006, 16'(lim));
    battery_sense_mv <= 16'h1b58;
    settle();
    chk("phase", 16'(CVT_FAST), 16'(phase));
    chk("sys at min", 16'h0000, 16'(sysmin));
    chk("limit", 16'h0008, 16'(lim));
    $display("t_multi_cell done");
  endtask : t_multi_cell

  // Main sequence; every input has a value at time zero.
  initial begin
    srst = 1'b1;
    cell_count_pin = 2'h0;
    input_good_flag = 1'b0;
    linear_pass_enable = 1'b1;
    battery_sense_mv = 16'h0000;
    min_system_voltage_mv = 16'h0000;
    reg_rd_addr = 8'h00;
    t_reset();
    t_range();
    t_one_cell();
    t_multi_cell();
    test_done();
  end
endmodule : tb_top
